/* File: hw/bfcc_ctrl.sv */
`timescale 1ns/100ps
module bfcc_ctrl #(
    parameter int TICK_CYC = bfcc_pkg::TICK_CYC,
    parameter int TOPOFF_OFF_CYC = bfcc_pkg::TOPOFF_OFF_CYC,
    parameter int TRICKLE_OFF_CYC = bfcc_pkg::TRICKLE_OFF_CYC,
    parameter int MCV_HOLD_MS = bfcc_pkg::MCV_HOLD_MS,
    parameter int SAFETY_BASE_MS = bfcc_pkg::SAFETY_BASE_MS,
    parameter int HOLDOFF_BASE_MS = bfcc_pkg::HOLDOFF_BASE_MS
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic discharge_request_n,
    input wire logic suspend_n,
    input wire logic supply_good,
    input wire logic [1:0] voltage_term_select,
    input wire logic [1:0] timer_mode_sel_1,
    input wire logic [1:0] timer_mode_sel_2,
    input wire logic [1:0] display_select,
    input wire logic cell_below_empty,
    input wire logic cell_above_max,
    input wire logic temp_below_cutoff,
    input wire logic temp_too_cold,
    input wire logic temp_too_hot,
    input wire logic temp_rate_trip,
    input wire logic peak_voltage_term,
    input wire logic neg_delta_trip,
    input wire logic sense_ref_grounded,
    input wire logic sense_over_limit,
    output logic charge_gate,
    output logic charge_gate_oe,
    output logic discharge_drive,
    output logic discharge_drive_oe,
    output logic status_lamp_1,
    output logic status_lamp_1_oe,
    output logic status_lamp_2,
    output logic status_lamp_2_oe,
    output logic low_power
);
    logic [bfcc_pkg::SYNC_W-1:0] s; // Synchronised pins
    bfcc_pkg::bfcc_state_t state;
    bfcc_pkg::bfcc_state_t next_state;
    logic dreq_prev, susp_prev, supply_prev, maxv_prev; // Edge history
    logic dreq_fall, susp_rise, supply_rise, maxv_fall;
    logic start_cycle; // Any new-cycle cause
    logic pvd_mode, neg_mode, topoff_en, trickle_en;
    logic [1:0] rate; // Fast-charge rate step
    logic [31:0] safety_ms, holdoff_ms;
    logic [31:0] tick_cnt, next_tick_cnt;
    logic [31:0] elapsed_ms, next_elapsed_ms; // Time in current state
    logic timeout, holdoff_done, qual_ok, term_fast, blink;
    logic next_gate, next_gate_oe, next_dis, next_l1, next_l2, next_lp;
    logic run_ok; // No override pending this cycle
    logic [1:0] fill; // Synchroniser holds real pin levels once both bits are set
    bfcc_pulse_if pif ();

    // Comparator inputs already read relative to the sense reference
    bfcc_sync #(.W(bfcc_pkg::SYNC_W), .INIT(bfcc_pkg::SYNC_INIT)) u_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .clk_en(clk_en),
        .d_in({display_select, timer_mode_sel_2, timer_mode_sel_1, voltage_term_select,
               sense_over_limit, sense_ref_grounded, neg_delta_trip, peak_voltage_term,
               temp_rate_trip, temp_too_hot, temp_too_cold, temp_below_cutoff,
               cell_above_max, cell_below_empty, supply_good, suspend_n,
               discharge_request_n}),
        .q(s)
    );

    bfcc_pulse_gen u_pulse (
        .sys_clk(sys_clk),
        .rst(rst),
        .clk_en(clk_en),
        .pif(pif.gen)
    );

    // Edge detection on synchronised levels only
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            dreq_prev <= 1'b1;
            susp_prev <= 1'b1;
            supply_prev <= 1'b0;
            maxv_prev <= 1'b0;
            fill <= 2'h0;
        end else if (clk_en) begin
            dreq_prev <= s[bfcc_pkg::S_DREQ];
            susp_prev <= s[bfcc_pkg::S_SUSP];
            supply_prev <= s[bfcc_pkg::S_SUPPLY];
            maxv_prev <= s[bfcc_pkg::S_MAXV];
            fill <= {fill[0], 1'b1};
        end
    end

    // Configuration decode and cycle-start causes
    always_comb begin
        dreq_fall = dreq_prev && !s[bfcc_pkg::S_DREQ];
        susp_rise = !susp_prev && s[bfcc_pkg::S_SUSP];
        supply_rise = !supply_prev && s[bfcc_pkg::S_SUPPLY];
        maxv_fall = maxv_prev && !s[bfcc_pkg::S_MAXV];
        // Insertion shows as the cell falling through the maximum level
        start_cycle = susp_rise || supply_rise || (state == bfcc_pkg::ST_ABSENT && maxv_fall);
        pvd_mode = s[bfcc_pkg::S_VOLTAGE_TERM_SELECT +: 2] == bfcc_pkg::TRI_HIGH;
        neg_mode = s[bfcc_pkg::S_VOLTAGE_TERM_SELECT +: 2] == bfcc_pkg::TRI_FLOAT;
        // Rate steps through the first selector, one more if the second is high
        rate = s[bfcc_pkg::S_TM1 +: 2] + {1'b0, s[bfcc_pkg::S_TM2 +: 2] == bfcc_pkg::TRI_HIGH};
        topoff_en = s[bfcc_pkg::S_TM2 +: 2] == bfcc_pkg::TRI_FLOAT;
        trickle_en = !(s[bfcc_pkg::S_TM1 +: 2] == bfcc_pkg::TRI_LOW
                       && s[bfcc_pkg::S_TM2 +: 2] == bfcc_pkg::TRI_LOW);
        safety_ms = 32'(SAFETY_BASE_MS) >> rate;
        holdoff_ms = 32'(HOLDOFF_BASE_MS) >> rate;
        timeout = elapsed_ms >= safety_ms;
        holdoff_done = elapsed_ms >= holdoff_ms;
        blink = elapsed_ms[bfcc_pkg::FLASH_BIT];
        run_ok = clk_en && s[bfcc_pkg::S_SUSP] && !dreq_fall && !start_cycle;
        // Cold limit ignored in peak-voltage mode; reset idle levels never qualify
        qual_ok = !s[bfcc_pkg::S_EMPTY] && !s[bfcc_pkg::S_MAXV] && !s[bfcc_pkg::S_HOT]
                  && (pvd_mode || !s[bfcc_pkg::S_COLD]) && fill[1];
        term_fast = s[bfcc_pkg::S_RATE] || (pvd_mode && s[bfcc_pkg::S_PEAK])
                    || (neg_mode && holdoff_done && s[bfcc_pkg::S_NEG])
                    || (!pvd_mode && s[bfcc_pkg::S_COLD]) || timeout;
    end

    // Sequencer next state; suspend beats everything, then the request
    always_comb begin
        next_state = state;
        if (!s[bfcc_pkg::S_SUSP]) begin
            next_state = bfcc_pkg::ST_SUSP;
        end else if (dreq_fall) begin
            next_state = bfcc_pkg::ST_DISCH;
        end else if (start_cycle) begin
            // Held request makes discharge the first step
            next_state = s[bfcc_pkg::S_DREQ] ? bfcc_pkg::ST_QUAL : bfcc_pkg::ST_DISCH;
        end else begin
            unique case (state)
                bfcc_pkg::ST_SUSP: begin
                    next_state = s[bfcc_pkg::S_DREQ] ? bfcc_pkg::ST_QUAL : bfcc_pkg::ST_DISCH;
                end
                bfcc_pkg::ST_DISCH: begin
                    if (s[bfcc_pkg::S_EMPTY]) begin
                        next_state = bfcc_pkg::ST_QUAL;
                    end
                end
                bfcc_pkg::ST_QUAL: begin
                    if (s[bfcc_pkg::S_MAXV]) begin
                        next_state = bfcc_pkg::ST_ABSENT;
                    end else if (qual_ok) begin
                        next_state = bfcc_pkg::ST_FAST;
                    end
                    // Otherwise pending, trickling when enabled, with no time limit
                end
                bfcc_pkg::ST_FAST: begin
                    if (s[bfcc_pkg::S_MAXV]) begin
                        next_state = bfcc_pkg::ST_MCV;
                    end else if (s[bfcc_pkg::S_CUT]) begin
                        next_state = bfcc_pkg::ST_TRICKLE;
                    end else if (term_fast) begin
                        next_state = topoff_en ? bfcc_pkg::ST_TOPOFF : bfcc_pkg::ST_TRICKLE;
                    end
                end
                bfcc_pkg::ST_TOPOFF: begin
                    if (s[bfcc_pkg::S_MAXV]) begin
                        next_state = bfcc_pkg::ST_MCV;
                    end else if (s[bfcc_pkg::S_CUT] || timeout) begin
                        next_state = bfcc_pkg::ST_TRICKLE;
                    end
                end
                bfcc_pkg::ST_TRICKLE: begin
                    next_state = state;
                end
                bfcc_pkg::ST_MCV: begin
                    // Quick fall back means full; staying high means removed
                    if (!s[bfcc_pkg::S_MAXV]) begin
                        next_state = bfcc_pkg::ST_TRICKLE;
                    end else if (elapsed_ms >= 32'(MCV_HOLD_MS)) begin
                        next_state = bfcc_pkg::ST_ABSENT;
                    end
                end
                bfcc_pkg::ST_ABSENT: begin
                    next_state = state;
                end
            endcase
        end
        if (!clk_en) begin
            next_state = state;
        end
    end

    // Millisecond timebase, cleared on every state change
    always_comb begin
        next_tick_cnt = tick_cnt;
        next_elapsed_ms = elapsed_ms;
        if (clk_en) begin
            if (next_state != state) begin
                next_tick_cnt = '0;
                next_elapsed_ms = '0;
            end else if (tick_cnt >= 32'(TICK_CYC - 1)) begin
                next_tick_cnt = '0;
                // Saturate so a long trickle never wraps into a timeout
                next_elapsed_ms = (&elapsed_ms) ? elapsed_ms : elapsed_ms + 32'h1;
            end else begin
                next_tick_cnt = tick_cnt + 32'h1;
            end
        end
    end

    // Modulator setup: top-off duty or the trickle period
    always_comb begin
        pif.run = (state == bfcc_pkg::ST_TOPOFF)
                  || (trickle_en && (state == bfcc_pkg::ST_TRICKLE || state == bfcc_pkg::ST_QUAL));
        pif.on_len = 32'(bfcc_pkg::TOPOFF_ON_CYC);
        if (state == bfcc_pkg::ST_TOPOFF) begin
            pif.period_len = 32'(bfcc_pkg::TOPOFF_ON_CYC + TOPOFF_OFF_CYC);
        end else if (topoff_en) begin
            // Half the trickle rate when top-off is selected
            pif.period_len = 32'(bfcc_pkg::TOPOFF_ON_CYC + 2 * TRICKLE_OFF_CYC);
        end else begin
            pif.period_len = 32'(bfcc_pkg::TOPOFF_ON_CYC + TRICKLE_OFF_CYC);
        end
    end

    // Output values from the coming state
    always_comb begin
        next_gate = 1'b0;
        next_dis = next_state == bfcc_pkg::ST_DISCH;
        next_l1 = 1'b0;
        next_l2 = 1'b0;
        next_lp = !s[bfcc_pkg::S_SUSP];
        next_gate_oe = s[bfcc_pkg::S_SUSP];
        unique case (next_state)
            bfcc_pkg::ST_FAST: begin
                // Plain on/off when the reference is grounded, else hysteretic
                next_gate = s[bfcc_pkg::S_REFG] || !s[bfcc_pkg::S_OVER];
            end
            bfcc_pkg::ST_TOPOFF, bfcc_pkg::ST_TRICKLE, bfcc_pkg::ST_QUAL: begin
                next_gate = pif.pulse;
            end
            default: begin
                next_gate = 1'b0;
            end
        endcase
        // Lamp encoding; all dark while the maximum-voltage check runs
        case (s[bfcc_pkg::S_DISPLAY_SELECT +: 2])
            bfcc_pkg::TRI_LOW: begin
                next_l1 = next_state inside {bfcc_pkg::ST_FAST, bfcc_pkg::ST_TOPOFF};
                next_l2 = next_state == bfcc_pkg::ST_TRICKLE;
            end
            bfcc_pkg::TRI_HIGH: begin
                next_l1 = next_state == bfcc_pkg::ST_QUAL;
                next_l2 = next_state inside {bfcc_pkg::ST_FAST, bfcc_pkg::ST_TOPOFF}
                          || (next_state == bfcc_pkg::ST_TRICKLE && blink);
            end
            default: begin
                next_l1 = next_state inside {bfcc_pkg::ST_FAST, bfcc_pkg::ST_TOPOFF}
                          || (next_state == bfcc_pkg::ST_QUAL && blink);
                next_l2 = next_state == bfcc_pkg::ST_TRICKLE
                          || (next_state == bfcc_pkg::ST_ABSENT && blink);
            end
        endcase
    end

    // State, timers and every top output registered here
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state <= bfcc_pkg::ST_QUAL;
            tick_cnt <= '0;
            elapsed_ms <= '0;
            charge_gate <= 1'b0;
            charge_gate_oe <= 1'b1;
            discharge_drive <= 1'b0;
            discharge_drive_oe <= 1'b1;
            status_lamp_1 <= 1'b0;
            status_lamp_1_oe <= 1'b1;
            status_lamp_2 <= 1'b0;
            status_lamp_2_oe <= 1'b1;
            low_power <= 1'b0;
        end else if (clk_en) begin
            state <= next_state;
            tick_cnt <= next_tick_cnt;
            elapsed_ms <= next_elapsed_ms;
            charge_gate <= next_gate && next_gate_oe;
            charge_gate_oe <= next_gate_oe;
            discharge_drive <= next_dis && next_gate_oe;
            discharge_drive_oe <= next_gate_oe;
            status_lamp_1 <= next_l1 && next_gate_oe;
            status_lamp_1_oe <= next_gate_oe;
            status_lamp_2 <= next_l2 && next_gate_oe;
            status_lamp_2_oe <= next_gate_oe;
            low_power <= next_lp;
        end
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    susp_float_a: assert property (clk_en && !s[bfcc_pkg::S_SUSP] |=>
        !charge_gate_oe && !discharge_drive_oe && !status_lamp_1_oe && low_power)
        else $error("outputs not floated during suspend");
    dis_request_a: assert property (clk_en && s[bfcc_pkg::S_SUSP] && dreq_fall |=>
        state == bfcc_pkg::ST_DISCH && discharge_drive)
        else $error("request pulse did not start discharge");
    dis_empty_a: assert property (run_ok && state == bfcc_pkg::ST_DISCH
        && s[bfcc_pkg::S_EMPTY] |=> state == bfcc_pkg::ST_QUAL && !discharge_drive)
        else $error("discharge did not end at empty");
    hold_dis_a: assert property (clk_en && s[bfcc_pkg::S_SUSP] && !dreq_fall && start_cycle
        && !s[bfcc_pkg::S_DREQ] |=> state == bfcc_pkg::ST_DISCH)
        else $error("held request skipped discharge");
    resume_cycle_a: assert property (clk_en && susp_rise && s[bfcc_pkg::S_DREQ]
        |=> state == bfcc_pkg::ST_QUAL ##1 !low_power)
        else $error("suspend release did not restart");
    qual_wait_a: assert property (clk_en && state == bfcc_pkg::ST_QUAL && !qual_ok
        |=> state != bfcc_pkg::ST_FAST)
        else $error("fast charge without qualification");
    absent_enter_a: assert property (run_ok && state == bfcc_pkg::ST_QUAL
        && s[bfcc_pkg::S_MAXV] |=> state == bfcc_pkg::ST_ABSENT)
        else $error("overvoltage did not mark battery absent");
    cutoff_end_a: assert property (run_ok && state inside {bfcc_pkg::ST_FAST,
        bfcc_pkg::ST_TOPOFF} && !s[bfcc_pkg::S_MAXV] && s[bfcc_pkg::S_CUT]
        |=> state == bfcc_pkg::ST_TRICKLE)
        else $error("temperature cutoff ignored");
    gate_fixed_a: assert property (clk_en && s[bfcc_pkg::S_SUSP] && s[bfcc_pkg::S_REFG]
        && next_state == bfcc_pkg::ST_FAST |=> charge_gate && charge_gate_oe)
        else $error("gate not held high in fast charge");
    topoff_next_a: assert property (run_ok && state == bfcc_pkg::ST_FAST && term_fast
        && topoff_en && !s[bfcc_pkg::S_MAXV] && !s[bfcc_pkg::S_CUT]
        |=> state == bfcc_pkg::ST_TOPOFF)
        else $error("top-off skipped after fast charge");

    fast_topoff_c: cover property (state == bfcc_pkg::ST_FAST ##1 state == bfcc_pkg::ST_TOPOFF);
    dis_done_c: cover property (state == bfcc_pkg::ST_DISCH ##1 state == bfcc_pkg::ST_QUAL);
    mcv_absent_c: cover property (state == bfcc_pkg::ST_MCV ##1 state == bfcc_pkg::ST_ABSENT);
    fast_trickle_c: cover property (state == bfcc_pkg::ST_FAST ##1 state == bfcc_pkg::ST_TRICKLE);
endmodule : bfcc_ctrl

/* File: hw/bfcc_pkg.sv */
package bfcc_pkg;
    // Core clock: 10 MHz, 100 ns period
    localparam int CLK_MHZ = 10;
    // Top-off duty cycle, as printed
    localparam int TOPOFF_ON_US = 260;
    localparam int TOPOFF_OFF_US = 1820;
    localparam int TOPOFF_ON_CYC = TOPOFF_ON_US * CLK_MHZ;
    localparam int TOPOFF_OFF_CYC = TOPOFF_OFF_US * CLK_MHZ;
    // Trickle off time at the C/32 setting; doubled when top-off is on
    localparam int TRICKLE_OFF_US = 16380;
    localparam int TRICKLE_OFF_CYC = TRICKLE_OFF_US * CLK_MHZ;
    // Millisecond tick feeding the long timers
    localparam int TICK_US = 1000;
    localparam int TICK_CYC = TICK_US * CLK_MHZ;
    // Maximum-voltage wait before declaring the battery absent
    localparam int MCV_HOLD_MS = 1500;
    // Safety timer and hold-off at the slowest rate; halved per rate step
    localparam int SAFETY_BASE_MS = 96000;
    localparam int HOLDOFF_BASE_MS = 16000;
    // Elapsed-time bit used to blink the lamps
    localparam int FLASH_BIT = 9;
    // Three-state pin codes from the pin level detector
    localparam logic [1:0] TRI_LOW = 2'h0;
    localparam logic [1:0] TRI_FLOAT = 2'h1;
    localparam logic [1:0] TRI_HIGH = 2'h2;
    // Positions in the synchronised input vector
    localparam int S_DREQ = 0;
    localparam int S_SUSP = 1;
    localparam int S_SUPPLY = 2;
    localparam int S_EMPTY = 3;
    localparam int S_MAXV = 4;
    localparam int S_CUT = 5;
    localparam int S_COLD = 6;
    localparam int S_HOT = 7;
    localparam int S_RATE = 8;
    localparam int S_PEAK = 9;
    localparam int S_NEG = 10;
    localparam int S_REFG = 11;
    localparam int S_OVER = 12;
    localparam int S_VOLTAGE_TERM_SELECT = 13;
    localparam int S_TM1 = 15;
    localparam int S_TM2 = 17;
    localparam int S_DISPLAY_SELECT = 19;
    localparam int SYNC_W = 21;
    // Active-low request and suspend idle high
    localparam logic [SYNC_W-1:0] SYNC_INIT = 21'h000003;
    // Charge sequencer states
    typedef enum logic [2:0] {
        ST_SUSP, ST_DISCH, ST_QUAL, ST_FAST, ST_TOPOFF, ST_TRICKLE, ST_MCV, ST_ABSENT
    } bfcc_state_t;
endpackage : bfcc_pkg

/* File: hw/bfcc_pulse_if.sv */
`timescale 1ns/100ps
// Pulse request from the sequencer and the modulated answer
interface bfcc_pulse_if;
    logic run; // Modulator running
    logic [31:0] on_len; // Active cycles per period
    logic [31:0] period_len; // Whole period in cycles
    logic pulse; // Modulated gate request
    modport ctrl (output run, output on_len, output period_len, input pulse);
    modport gen (input run, input on_len, input period_len, output pulse);
endinterface : bfcc_pulse_if

/* File: hw/bfcc_sync.sv */
`timescale 1ns/100ps
// Two-flop synchroniser bank for pin-level inputs
module bfcc_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q
);
    logic [W-1:0] meta; // First stage, read only by q
    logic [W-1:0] next_meta;
    logic [W-1:0] next_q;

    // One pair of flops per bit
    for (genvar i = 0; i < W; i++) begin : g_bit
        always_comb begin
            next_meta[i] = clk_en ? d_in[i] : meta[i];
            next_q[i] = clk_en ? meta[i] : q[i];
        end
    end

    // Idle levels at reset keep edges from firing falsely
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            meta <= INIT;
            q <= INIT;
        end else begin
            meta <= next_meta;
            q <= next_q;
        end
    end
endmodule : bfcc_sync

/* File: hw/bfcc_pulse_gen.sv */
`timescale 1ns/100ps
// Fixed-width pulse modulator for top-off and trickle rates
module bfcc_pulse_gen (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    bfcc_pulse_if.gen pif
);
    logic [31:0] cnt; // Position in the period
    logic [31:0] next_cnt;
    logic next_pulse;

    // Restart from the active part whenever the modulator is stopped
    always_comb begin
        next_cnt = cnt;
        next_pulse = pif.pulse;
        if (clk_en) begin
            if (!pif.run || cnt >= pif.period_len - 32'h1) begin
                next_cnt = '0;
            end else begin
                next_cnt = cnt + 32'h1;
            end
            next_pulse = pif.run && (cnt < pif.on_len);
        end
    end

    // Registers only
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cnt <= '0;
            pif.pulse <= 1'b0;
        end else begin
            cnt <= next_cnt;
            pif.pulse <= next_pulse;
        end
    end
endmodule : bfcc_pulse_gen

/* File: bench/bfcc_batt_model.sv */
`timescale 1ns/100ps
// Battery behind the switches; level in steps
module bfcc_batt_model (
    input wire logic sys_clk,
    input wire logic charge_gate,
    input wire logic charge_gate_oe,
    input wire logic discharge_drive,
    input wire logic discharge_drive_oe,
    input wire logic over_volt,
    output logic cell_below_empty,
    output logic cell_above_max
);
    int level = 60; // Cell voltage
    // Floating pins leave the cell idle
    always @(posedge sys_clk) begin
        if (discharge_drive & discharge_drive_oe & (level > 0)) begin
            level <= level - 1;
        end else if (charge_gate & charge_gate_oe & (level < 90)) begin
            level <= level + 1;
        end
    end
    // Comparators against the sense reference
    assign cell_below_empty = (level < 20);
    assign cell_above_max = over_volt;
endmodule : bfcc_batt_model

/* File: bench/tb_battery_fast_charge_controller.sv */
`timescale 1ns/100ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin err_count++; \
    $display("[ERR] %0t %h %h", $time, (a), (e)); end end
module tb_battery_fast_charge_controller;
    logic sys_clk = 1'b0, rst = 1'b1, clk_en = 1'b1, supply_good = 1'b0;
    logic discharge_request_n = 1'b1, suspend_n = 1'b1, over_volt = 1'b0;
    logic [1:0] voltage_term_select = 2'h0, display_select = 2'h0;
    logic [1:0] timer_mode_sel_1 = 2'h0, timer_mode_sel_2 = 2'h0; // No trickle
    logic temp_below_cutoff = 1'b0, temp_too_cold = 1'b0, temp_too_hot = 1'b0;
    logic temp_rate_trip = 1'b0, peak_voltage_term = 1'b0, neg_delta_trip = 1'b0;
    logic sense_ref_grounded = 1'b1, sense_over_limit = 1'b0; // Plain gating
    logic cell_below_empty, cell_above_max, charge_gate, charge_gate_oe;
    logic discharge_drive, discharge_drive_oe, status_lamp_1, status_lamp_1_oe;
    logic status_lamp_2, status_lamp_2_oe, low_power;
    int err_count = 0, check_count = 0, cyc = 0;
    // Short timers: 4-cycle tick, safety 200 cycles, hold-off 40
    bfcc_ctrl #(.TICK_CYC(4), .TOPOFF_OFF_CYC(20), .TRICKLE_OFF_CYC(40), .MCV_HOLD_MS(20),
        .SAFETY_BASE_MS(50), .HOLDOFF_BASE_MS(10)) i_bfcc_ctrl (.sys_clk, .rst, .clk_en,
        .discharge_request_n, .suspend_n, .supply_good, .voltage_term_select,
        .timer_mode_sel_1, .timer_mode_sel_2, .display_select, .cell_below_empty,
        .cell_above_max, .temp_below_cutoff, .temp_too_cold, .temp_too_hot, .temp_rate_trip,
        .peak_voltage_term, .neg_delta_trip, .sense_ref_grounded, .sense_over_limit,
        .charge_gate, .charge_gate_oe, .discharge_drive, .discharge_drive_oe, .status_lamp_1,
        .status_lamp_1_oe, .status_lamp_2, .status_lamp_2_oe, .low_power);
    bfcc_batt_model i_bfcc_batt_model (.sys_clk, .charge_gate, .charge_gate_oe,
        .discharge_drive, .discharge_drive_oe, .over_volt, .cell_below_empty, .cell_above_max);
    initial begin
        forever #50 sys_clk = ~sys_clk;
    end
    // Hang guard
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            test_done();
        end
    end
    task automatic test_done();
        if (err_count == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done
    // Inputs move 5 ns after the edge
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #5;
    endtask : step
    // Supply rise starts a cycle
    task automatic restart();
        supply_good = 1'b0;
        step(4);
        supply_good = 1'b1;
        step(8);
    endtask : restart
    // Bounded wait for the cell to drain
    task automatic drain();
        for (int i = 0; i < 300 && discharge_drive === 1'b1; i++) step(1);
        `CHK(discharge_drive, 1'b0)
        step(8);
        `CHK(charge_gate, 1'b1)
    endtask : drain
    task automatic s_qual();
        display_select = 2'h2;
        temp_too_hot = 1'b1;
        restart();
        `CHK({status_lamp_1, charge_gate}, 2'h2)
        temp_too_hot = 1'b0;
        display_select = 2'h0;
        step(8);
        `CHK({status_lamp_1, charge_gate}, 2'h3)
    endtask : s_qual
    // Rate, peak, cutoff and negative-delta trips, then the safety timer; negative delta ignored when disabled
    task automatic s_term();
        for (int k = 0; k < 5; k++) begin
            voltage_term_select = (k == 1) ? 2'h2 : ((k == 3) ? 2'h1 : 2'h0);
            restart();
            step(50);
            `CHK(status_lamp_1, 1'b1)
            {temp_rate_trip, peak_voltage_term} = {k == 0, k == 1};
            {temp_below_cutoff, neg_delta_trip} = {k == 2, k >= 3};
            step(8);
            `CHK({charge_gate, status_lamp_2}, (k == 4) ? 2'h2 : 2'h1)
            {temp_rate_trip, peak_voltage_term, temp_below_cutoff, neg_delta_trip} = 4'h0;
        end
        restart();
        step(180);
        `CHK(status_lamp_1, 1'b1)
        step(40);
        `CHK({status_lamp_1, status_lamp_2}, 2'h1)
    endtask : s_term
    // Trickle and top-off on, so a drained cell can requalify
    task automatic s_disch();
        timer_mode_sel_2 = 2'h1;
        restart();
        discharge_request_n = 1'b0;
        step(4);
        discharge_request_n = 1'b1;
        step(4);
        `CHK({discharge_drive, charge_gate}, 2'h2)
        drain();
        // Held low: the fall drains first, the next cycle start drains again
        discharge_request_n = 1'b0;
        step(4);
        drain();
        step(30);
        restart();
        `CHK(discharge_drive, 1'b1)
        drain();
        discharge_request_n = 1'b1;
        // Trip into top-off with the hysteretic gate held off
        {temp_rate_trip, sense_ref_grounded, sense_over_limit} = 3'h5;
        step(8);
        `CHK({status_lamp_1, status_lamp_2, charge_gate}, 3'h5)
        {temp_rate_trip, sense_ref_grounded, sense_over_limit} = 3'h2;
        timer_mode_sel_2 = 2'h0;
    endtask : s_disch
    task automatic s_susp();
        suspend_n = 1'b0;
        step(4);
        `CHK({charge_gate_oe, discharge_drive_oe, status_lamp_1_oe, status_lamp_2_oe, low_power}, 5'h01)
        suspend_n = 1'b1;
        step(8);
        `CHK({charge_gate_oe, status_lamp_1}, 2'h3)
        over_volt = 1'b1;
        restart();
        step(100);
        `CHK({charge_gate, status_lamp_1}, 2'h0)
        over_volt = 1'b0;
        step(10);
        `CHK(status_lamp_1, 1'b1)
    endtask : s_susp
    initial begin
        step(3);
        `CHK({charge_gate, charge_gate_oe, low_power}, 3'h2)
        rst = 1'b0;
        s_qual();
        s_term();
        s_disch();
        s_susp();
        test_done();
    end
endmodule : tb_battery_fast_charge_controller
